// ===== hdl/pcr_pkg.sv
// Purpose: shared constants and carrier types for the processor control register bank
// Assumes: apb with 32-bit data, registers in the low 16 bits of each aligned word
// Notes: offsets are word indices, so the byte address is four times the index
package pcr_pkg;
	// register indices; the apb byte address is four times these
	localparam logic [15:0] IDX_BASE  = 16'hC002;
	localparam logic [15:0] IDX_REV   = 16'hC004;
	localparam logic [15:0] IDX_SPEED = 16'hC008;
	localparam logic [15:0] IDX_POWER = 16'hC00A;
	localparam logic [15:0] IDX_IRQST = 16'hC0F0;
	localparam logic [15:0] IDX_IRQMK = 16'hC0F2;
	// reset values
	localparam logic [15:0] RST_BASE  = 16'h0100;
	localparam logic [3:0]  RST_SPEED = 4'hF;
	localparam logic [15:0] RST_POWER = 16'h0000;
	localparam logic [15:0] REV_VALUE = 16'h0A5A;  // arbitrary revision value
	// base field and power control bit positions
	localparam int BASE_LSB  = 4;
	localparam int PW_H2     = 14;
	localparam int PW_H1     = 12;
	localparam int PW_OTG    = 11;
	localparam int PW_HSS    = 9;
	localparam int PW_SPI    = 8;
	localparam int PW_HPI    = 7;
	localparam int PW_PIN    = 4;
	localparam int PW_BOOST  = 2;
	localparam int PW_SLEEP  = 1;
	localparam int PW_HALT   = 0;
	localparam logic [15:0] PW_WMASK = 16'h5B90;   // writable wake enables
	localparam logic [15:0] BASE_WMASK = 16'hFFF0; // writable base field
	// event bits in the interrupt status register
	localparam int EV_WAKE  = 0;
	localparam int EV_SLEEP = 1;
	localparam int EV_HALT  = 2;
	localparam int EV_RESUME = 3;
	localparam int EV_W     = 4;
	// power state machine
	typedef enum logic [1:0]
	{
		PCR_RUN   = 2'b00,
		PCR_SLEEP = 2'b01,
		PCR_HALT  = 2'b10
	} pcr_state_e;
	// synchronised wake inputs
	typedef struct packed
	{
		logic       usb2;
		logic       usb1;
		logic       otg_vbus;
		logic       otg_id;
		logic       hss_rx;
		logic       spi_ssn;
		logic       hpi_rd;
		logic [1:0] pins;
	} pcr_wake_s;
endpackage

// ===== hdl/pcr_regs.sv
// Purpose: processor control register bank: base, revision, core divider, power control
// Assumes: pclk is the undivided system clock; wake inputs are asynchronous pins
// Notes: sleep stops only the core here; clock gating itself lives outside this block
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module pcr_regs
(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// core register address path
	input  wire logic [3:0]         reg_index,
	output logic      [15:0]        reg_ram_addr,
	// core clocking and power
	input  wire logic               core_irq,
	output logic                    core_tick,
	output logic                    core_sleep,
	output logic                    core_halt,
	output logic                    drop_rx_byte,
	// asynchronous wake and status pins
	input  wire pcr_pkg::pcr_wake_s wake_pins,
	input  wire logic               boost_rail_status,
	// interrupt
	output logic                    irq
);
	// register storage
	logic [15:0]              base;          // base field, low bits kept zero
	logic [3:0]               speed;         // core divider select
	logic [15:0]              power;         // wake enables only
	logic [3:0]               div_cnt;       // core divider counter
	pcr_pkg::pcr_state_e      state;         // run, sleep or halt
	pcr_pkg::pcr_wake_s       sync1;         // first synchroniser stage
	pcr_pkg::pcr_wake_s       sync2;         // second synchroniser stage
	pcr_pkg::pcr_wake_s       prev;          // last sampled synchronised value
	logic                     boost1;        // boost status stage one
	logic                     boost2;        // boost status stage two
	logic                     irq_sync1;     // core interrupt stage one
	logic                     irq_sync2;     // core interrupt stage two
	logic [pcr_pkg::EV_W-1:0] irq_status;    // sticky events
	logic [pcr_pkg::EV_W-1:0] irq_mask;      // event enables
	logic                     wake_hit;      // any enabled wake this cycle
	logic                     irq_wake;      // enabled wake that may raise an interrupt
	logic                     rx_wake;       // wake by serial or slave-select
	logic                     wr_cyc;        // write access phase
	logic                     rd_cyc;        // read access phase
	logic [15:0]              next_rdata;    // read mux output
	logic                     next_err;      // unmapped address

	// word address to register index, shared by read and write decode
	// the full 32-bit address is compared, so aliases above the bank
	// fall through to the unmapped answer instead of hitting a register
	function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
		hit = (addr == {14'h0, idx, 2'b00});
	endfunction

	// apb is answered in the access phase with no wait states
	// a write lands only at the access edge, never in the setup cycle,
	// so a master that aborts after setup leaves every register untouched
	assign wr_cyc = psel && penable && pwrite;
	assign rd_cyc = psel && penable && !pwrite;

	// level pins cross into pclk through two flops each
	// only the second stage is read by logic; the first may be metastable
	// a pulse shorter than one pclk period can be missed, which is accepted
	// because every wake source is a slow level or a held edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1     <= '0;
			sync2     <= '0;
			boost1    <= 1'b0;
			boost2    <= 1'b0;
			irq_sync1 <= 1'b0;
			irq_sync2 <= 1'b0;
		end
		else
		begin
			sync1     <= wake_pins;
			sync2     <= sync1;
			boost1    <= boost_rail_status;
			boost2    <= boost1;
			irq_sync1 <= core_irq;
			irq_sync2 <= irq_sync1;
		end
	end

	// edge history, compared against the second stage only
	// its reset value is low, so an input idling high shows one rising edge
	// after reset; that edge is harmless since wakes only count in sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev <= '0;
		else
			prev <= sync2;
	end

	// enabled wake sources; usb wakes end sleep but raise no core interrupt
	// irq_wake leaves the two usb engines out so their wakes stay silent
	always_comb
	begin
		wake_hit = 1'b0;
		irq_wake = 1'b0;
		if (power[pcr_pkg::PW_H2] && (sync2.usb2 != prev.usb2))
			wake_hit = 1'b1;
		if (power[pcr_pkg::PW_H1] && (sync2.usb1 != prev.usb1))
			wake_hit = 1'b1;
		if (power[pcr_pkg::PW_OTG] && ((sync2.otg_vbus != prev.otg_vbus) || (sync2.otg_id != prev.otg_id)))
		begin
			wake_hit = 1'b1;
			irq_wake = 1'b1;
		end
		if (power[pcr_pkg::PW_HPI] && sync2.hpi_rd && !prev.hpi_rd)
		begin
			wake_hit = 1'b1;
			irq_wake = 1'b1;
		end
		if (power[pcr_pkg::PW_PIN] && (sync2.pins != prev.pins))
		begin
			wake_hit = 1'b1;
			irq_wake = 1'b1;
		end
		if (rx_wake)
		begin
			wake_hit = 1'b1;
			irq_wake = 1'b1;
		end
	end

	// serial and slave-select wakes also discard the arriving byte
	// the core needs far longer to restart than one byte takes to arrive,
	// so the byte that woke it can never be received intact
	always_comb
	begin
		rx_wake = 1'b0;
		if (power[pcr_pkg::PW_HSS] && (sync2.hss_rx != prev.hss_rx))
			rx_wake = 1'b1;
		if (power[pcr_pkg::PW_SPI] && !sync2.spi_ssn && prev.spi_ssn)
			rx_wake = 1'b1;
	end

	// base register: only the field is stored, reserved bits never change
	// masking on write keeps the low bits zero, so reads need no mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			base <= pcr_pkg::RST_BASE;
		else if (wr_cyc && hit(paddr, pcr_pkg::IDX_BASE))
			base <= pwdata[15:0] & pcr_pkg::BASE_WMASK;
	end

	// core divider select
	// only the low nibble is kept; reserved upper bits read as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			speed <= pcr_pkg::RST_SPEED;
		else if (wr_cyc && hit(paddr, pcr_pkg::IDX_SPEED))
			speed <= pwdata[3:0];
	end

	// wake enables; sleep and halt bits are commands and are not stored
	// keeping them out of storage means a later enable write cannot
	// re-enter sleep or halt by echoing back a stale command bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			power <= pcr_pkg::RST_POWER;
		else if (wr_cyc && hit(paddr, pcr_pkg::IDX_POWER))
			power <= pwdata[15:0] & pcr_pkg::PW_WMASK;
	end

	// power state: sleep wins over halt when both are written
	// sleep ends on any enabled wake edge, halt on the core interrupt level;
	// commands are only taken in run, since a stopped core cannot issue them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= pcr_pkg::PCR_RUN;
		else
		begin
			unique case (state)
				pcr_pkg::PCR_RUN:
				begin
					if (wr_cyc && hit(paddr, pcr_pkg::IDX_POWER) && pwdata[pcr_pkg::PW_SLEEP])
						state <= pcr_pkg::PCR_SLEEP;
					else if (wr_cyc && hit(paddr, pcr_pkg::IDX_POWER) && pwdata[pcr_pkg::PW_HALT])
						state <= pcr_pkg::PCR_HALT;
				end
				pcr_pkg::PCR_SLEEP:
				begin
					if (wake_hit)
						state <= pcr_pkg::PCR_RUN;
				end
				pcr_pkg::PCR_HALT:
				begin
					if (irq_sync2)
						state <= pcr_pkg::PCR_RUN;
				end
				default:
					state <= pcr_pkg::PCR_RUN;
			endcase
		end
	end

	// divider counts on the full clock; peripherals never see it
	// the counter restarts when the select drops below it, so a new,
	// smaller divisor takes effect at once instead of after a wrap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt <= 4'h0;
		else if (state != pcr_pkg::PCR_RUN || div_cnt >= speed)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end

	// one core tick every speed+1 cycles, none while stopped
	// a select of zero keeps the tick high, the core then runs undivided
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			core_tick <= 1'b0;
		else
			core_tick <= (state == pcr_pkg::PCR_RUN) && (div_cnt >= speed);
	end

	// stop indications to the core and byte drop to the receivers
	// the drop pulse lasts one cycle; receivers must latch it themselves
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_sleep   <= 1'b0;
			core_halt    <= 1'b0;
			drop_rx_byte <= 1'b0;
		end
		else
		begin
			core_sleep   <= (state == pcr_pkg::PCR_SLEEP);
			core_halt    <= (state == pcr_pkg::PCR_HALT);
			drop_rx_byte <= (state == pcr_pkg::PCR_SLEEP) && rx_wake;
		end
	end

	// working register address: index shifted by one, or with base, bit zero low
	// bit four is shared by the base and the top index bit, so a base with
	// bit four set folds the lower eight registers onto the upper eight
	// the address follows the index one cycle later, from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reg_ram_addr <= 16'h0000;
		else
			reg_ram_addr <= (base & pcr_pkg::BASE_WMASK) | {11'h0, reg_index, 1'b0};
	end

	// interrupt mask
	// same layout as the status register; a zero bit only hides the event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= '0;
		else if (wr_cyc && hit(paddr, pcr_pkg::IDX_IRQMK))
			irq_mask <= pwdata[pcr_pkg::EV_W-1:0];
	end

	// sticky events, cleared by reading; a new event in the read cycle survives
	// the clear is written first and the sets after it, so a set in the
	// same cycle overrides the clear; an event set at the setup edge is cleared unread
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= '0;
		else
		begin
			irq_status <= (rd_cyc && hit(paddr, pcr_pkg::IDX_IRQST)) ? '0 : irq_status;
			if (state == pcr_pkg::PCR_SLEEP && irq_wake)
				irq_status[pcr_pkg::EV_WAKE] <= 1'b1;
			if (state == pcr_pkg::PCR_RUN && wr_cyc && hit(paddr, pcr_pkg::IDX_POWER) && pwdata[pcr_pkg::PW_SLEEP])
				irq_status[pcr_pkg::EV_SLEEP] <= 1'b1;
			if (state == pcr_pkg::PCR_RUN && wr_cyc && hit(paddr, pcr_pkg::IDX_POWER) && !pwdata[pcr_pkg::PW_SLEEP]
				&& pwdata[pcr_pkg::PW_HALT])
				irq_status[pcr_pkg::EV_HALT] <= 1'b1;
			if (state == pcr_pkg::PCR_HALT && irq_sync2)
				irq_status[pcr_pkg::EV_RESUME] <= 1'b1;
		end
	end

	// level interrupt from flop
	// it lags the status by one cycle, so it falls one cycle after a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// read mux; reserved bits and unmapped reads give zero
	// decoded from the setup-cycle address, which the master holds stable
	// through the access phase, so the flopped answer matches the address
	always_comb
	begin
		next_rdata = 16'h0000;
		next_err   = 1'b0;
		if (hit(paddr, pcr_pkg::IDX_BASE))
			next_rdata = base;
		else if (hit(paddr, pcr_pkg::IDX_REV))
			next_rdata = pcr_pkg::REV_VALUE;
		else if (hit(paddr, pcr_pkg::IDX_SPEED))
			next_rdata = {12'h000, speed};
		else if (hit(paddr, pcr_pkg::IDX_POWER))
		begin
			next_rdata = power;
			next_rdata[pcr_pkg::PW_BOOST] = boost2;
		end
		else if (hit(paddr, pcr_pkg::IDX_IRQST))
			next_rdata = {12'h000, irq_status};
		else if (hit(paddr, pcr_pkg::IDX_IRQMK))
			next_rdata = {12'h000, irq_mask};
		else
			next_err = 1'b1;
	end

	// apb answer registered in the setup cycle so it stands in the access phase
	// flopping costs nothing here since the access phase is always one cycle,
	// and it keeps every bus output straight from a register
	// write data are returned as zero so nothing leaks onto the read bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && next_err;
			prdata  <= (psel && !penable && !pwrite) ? {16'h0000, next_rdata} : 32'h0000_0000;
		end
	end
endmodule

// ===== bench/pcr_regs_sva.sv
// Purpose: port-level checks for the processor control register bank
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: the base register is internal, so address checks use only the index bits
`timescale 1ns/100ps
module pcr_regs_sva
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// core side
	input wire logic [3:0]  reg_index,
	input wire logic [15:0] reg_ram_addr,
	input wire logic        core_irq,
	input wire logic        core_tick,
	input wire logic        core_sleep,
	input wire logic        core_halt,
	input wire logic        drop_rx_byte
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// byte addresses of the revision and power registers
	localparam logic [31:0] A_REV = {14'h0, pcr_pkg::IDX_REV, 2'b00};
	localparam logic [31:0] A_PWR = {14'h0, pcr_pkg::IDX_POWER, 2'b00};
	// a write that lands on the power register this edge
	wire logic pw_wr = psel && penable && pready && pwrite && paddr == A_PWR;

	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no ready one cycle after setup");
	property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
	property p_upper; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read half not zero");
	property p_rev; pready && !pwrite && paddr == A_REV |-> prdata[15:0] == pcr_pkg::REV_VALUE; endproperty
	a_rev: assert property (p_rev) else $error("revision read wrong");
	// guard on the previous edge so the value captured in reset is not compared
	property p_ram; $past(presetn) |-> reg_ram_addr[3:0] == {$past(reg_index[2:0]), 1'b0}; endproperty
	a_ram: assert property (p_ram) else $error("ram address low bits wrong");
	property p_sleep_in; pw_wr && pwdata[1] |-> ##[1:2] core_sleep; endproperty
	a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
	property p_halt_in; pw_wr && pwdata[0] && !pwdata[1] |-> ##[1:2] core_halt; endproperty
	a_halt_in: assert property (p_halt_in) else $error("halt not entered");
	property p_halt_out; core_halt && core_irq |-> ##[1:4] !core_halt; endproperty
	a_halt_out: assert property (p_halt_out) else $error("halt not ended by interrupt");
	property p_excl; !(core_sleep && core_halt); endproperty
	a_excl: assert property (p_excl) else $error("sleep and halt together");
	property p_no_tick; core_sleep && $past(core_sleep) |-> !core_tick; endproperty
	a_no_tick: assert property (p_no_tick) else $error("core tick while asleep");
	property p_drop; drop_rx_byte |-> core_sleep || $past(core_sleep) || $past(core_sleep, 2); endproperty
	a_drop: assert property (p_drop) else $error("byte dropped outside a wake");
	// main scenarios reached
	c_sleep: cover property ($rose(core_sleep));
	c_halt: cover property ($rose(core_halt));
	c_err: cover property (pslverr);
endmodule

bind pcr_regs pcr_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.reg_index(reg_index), .reg_ram_addr(reg_ram_addr), .core_irq(core_irq), .core_tick(core_tick),
	.core_sleep(core_sleep), .core_halt(core_halt), .drop_rx_byte(drop_rx_byte));

// ===== bench/testbench.sv
// Purpose: self-checking bench for the processor control register bank
// Assumes: wake inputs idle low except slave-select, which idles high
// Notes: scenarios share one reset and run in order
`timescale 1ns/100ps
module testbench;
	// clock, reset and apb master
	logic               pclk = 0;
	logic               presetn = 0;
	logic               psel = 0, penable = 0, pwrite = 0;
	logic        [31:0] paddr = 0, pwdata = 0, prdata;
	logic               pready, pslverr;
	// core side and pins
	logic        [3:0]  reg_index = 0;
	logic        [15:0] reg_ram_addr;
	logic               core_irq = 0, core_tick, core_sleep, core_halt, drop_rx_byte, irq;
	logic               boost_rail_status = 0;
	pcr_pkg::pcr_wake_s wake_pins = 9'h008;
	// counters and dropped-byte monitor
	int                 n_errors = 0, samples_checked = 0;
	logic               drop_seen = 0;
	// byte address is four times the register index
	localparam logic [31:0] A_BASE = {14'h0, pcr_pkg::IDX_BASE, 2'b00};
	localparam logic [31:0] A_REV = {14'h0, pcr_pkg::IDX_REV, 2'b00};
	localparam logic [31:0] A_SPD = {14'h0, pcr_pkg::IDX_SPEED, 2'b00};
	localparam logic [31:0] A_PWR = {14'h0, pcr_pkg::IDX_POWER, 2'b00};
	localparam logic [31:0] A_IST = {14'h0, pcr_pkg::IDX_IRQST, 2'b00};
	localparam logic [31:0] A_IMK = {14'h0, pcr_pkg::IDX_IRQMK, 2'b00};

	always #25 pclk = ~pclk;

	pcr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reg_index(reg_index), .reg_ram_addr(reg_ram_addr), .core_irq(core_irq), .core_tick(core_tick),
		.core_sleep(core_sleep), .core_halt(core_halt), .drop_rx_byte(drop_rx_byte),
		.wake_pins(wake_pins), .boost_rail_status(boost_rail_status), .irq(irq));

	// a dropped-byte pulse lasts one cycle, so latch it
	always @(posedge pclk)
		if (drop_rx_byte === 1'b1)
			drop_seen = 1'b1;

	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; the request stands until pready is sampled high
	// only the watchdog ends a wait that never sees pready
	task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		chk("ready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 16'h0, r, e);
		chk(what, exp, r);
	endtask

	// bounded wait on sleep (k 0) or halt (k 1)
	task automatic wait_for(input string what, input int k, input logic val, input int lim);
		int n;
		n = 0;
		while ((k == 0 ? core_sleep : core_halt) !== val && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		chk(what, {31'h0, val}, {31'h0, k == 0 ? core_sleep : core_halt});
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd("base reset", A_BASE, 32'h0100);
		rd("speed reset", A_SPD, 32'h000F);
		rd("power reset", A_PWR, 32'h0000);
		rd("revision", A_REV, {16'h0, pcr_pkg::REV_VALUE});
		apb(1'b0, A_BASE + 32'h4, 16'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask

	// base field, reserved low bits and address forming, incl. bit 4 overlap
	task automatic t_base();
		wr(A_BASE, 16'hFFFF);
		rd("base field", A_BASE, 32'hFFF0);
		wr(A_REV, 16'h1234);
		rd("revision kept", A_REV, {16'h0, pcr_pkg::REV_VALUE});
		wr(A_BASE, 16'h0230);
		for (int i = 0; i < 16; i++)
		begin
			reg_index <= i[3:0];
			repeat (3) @(posedge pclk);
			chk("ram address", {16'h0, 16'h0230 | (16'(i) << 1)}, {16'h0, reg_ram_addr});
		end
	endtask

	// tick spacing is speed plus one pclk cycles
	task automatic t_speed();
		int g;
		int sp[3] = '{0, 1, 15};
		for (int k = 0; k < 3; k++)
		begin
			wr(A_SPD, 16'(sp[k]));
			repeat (3)
			begin
				g = 0;
				do
				begin
					@(posedge pclk);
					g++;
				end
				while (core_tick !== 1'b1 && g < 40);
			end
			chk("tick gap", 32'(sp[k] + 1), 32'(g));
		end
	endtask

	task automatic t_power();
		wr(A_PWR, 16'hA468);
		rd("power reserved", A_PWR, 32'h0);
		wr(A_PWR, 16'h5B90);
		boost_rail_status <= 1'b1;
		repeat (4) @(posedge pclk);
		rd("power enables", A_PWR, 32'h5B94);
		boost_rail_status <= 1'b0;
	endtask

	// each source wakes when enabled, another source does not
	task automatic t_wake();
		int bits[9] = '{14, 12, 11, 11, 9, 8, 7, 4, 4};
		logic [8:0] pin[9] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h001, 9'h002};
		wr(A_IMK, 16'h000F);
		for (int k = 0; k < 9; k++)
		begin
			wr(A_PWR, 16'h0002 | (16'h1 << bits[k]));
			wait_for("sleep entry", 0, 1'b1, 8);
			rd("sleep status", A_IST, 32'h2);
			wake_pins <= wake_pins ^ pin[(k + 2) % 9];
			repeat (6) @(posedge pclk);
			wake_pins <= wake_pins ^ pin[(k + 2) % 9];
			repeat (6) @(posedge pclk);
			chk("disabled source", 32'h1, {31'h0, core_sleep});
			drop_seen = 1'b0;
			wake_pins <= wake_pins ^ pin[k];
			wait_for("wake", 0, 1'b0, 12);
			repeat (3) @(posedge pclk);
			chk("wake irq", 32'(k > 1), {31'h0, irq});
			chk("dropped byte", 32'(k == 4 || k == 5), {31'h0, drop_seen});
			rd("wake status", A_IST, 32'(k > 1));
			wake_pins <= wake_pins ^ pin[k];
			repeat (4) @(posedge pclk);
			chk("irq cleared", 32'h0, {31'h0, irq});
		end
	endtask

	// halt with events masked, ended by a core interrupt
	task automatic t_halt();
		wr(A_IMK, 16'h0000);
		wr(A_PWR, 16'h0001);
		wait_for("halt entry", 1, 1'b1, 8);
		repeat (20) @(posedge pclk);
		chk("halt holds", 32'h1, {31'h0, core_halt});
		chk("masked irq", 32'h0, {31'h0, irq});
		core_irq <= 1'b1;
		wait_for("halt exit", 1, 1'b0, 8);
		core_irq <= 1'b0;
		rd("halt status", A_IST, 32'hC);
		rd("status cleared", A_IST, 32'h0);
	endtask

	// reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_base();
		t_speed();
		t_power();
		t_wake();
		t_halt();
		test_done();
	end

	// the whole run needs a few hundred cycles
	initial
	begin
		#(50 * 20000);
		n_errors++;
		test_done();
	end
endmodule
